// >>> rtl/regulator_regs_pkg.sv
package regulator_regs_pkg;

   // ************************************************************
   // Register map (indices; byte address is four times the index)
   // ************************************************************
   localparam logic [5:0] REGULATOR_FIVE_CONTROL_INDEX  = 6'h1c;
   localparam logic [5:0] REGULATOR_SIX_CONTROL_INDEX   = 6'h1d;
   localparam logic [5:0] REGULATOR_SEVEN_CONTROL_INDEX = 6'h1e;
   localparam logic [5:0] REGULATOR_EIGHT_CONTROL_INDEX = 6'h1f;
   localparam logic [5:0] REGULATOR_FIVE_VOLTAGE_INDEX  = 6'h20;
   localparam logic [5:0] REGULATOR_SIX_VOLTAGE_INDEX   = 6'h21;
   localparam logic [5:0] REGULATOR_SEVEN_VOLTAGE_INDEX = 6'h22;
   localparam logic [5:0] REGULATOR_EIGHT_VOLTAGE_INDEX = 6'h23;

   localparam logic [3:0][5:0] CONTROL_INDEX = {
      REGULATOR_EIGHT_CONTROL_INDEX, REGULATOR_SEVEN_CONTROL_INDEX,
      REGULATOR_SIX_CONTROL_INDEX, REGULATOR_FIVE_CONTROL_INDEX};
   localparam logic [3:0][5:0] VOLTAGE_INDEX = {
      REGULATOR_EIGHT_VOLTAGE_INDEX, REGULATOR_SEVEN_VOLTAGE_INDEX,
      REGULATOR_SIX_VOLTAGE_INDEX, REGULATOR_FIVE_VOLTAGE_INDEX};

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int unsigned BIT_ENABLE     = 7;
   localparam int unsigned BIT_POWER_SAVE = 6;
   localparam int unsigned SEL_MSB        = 5;
   localparam int unsigned REGULATOR_FIVE = 0;

   typedef struct packed {
      logic       enable;
      logic       power_save_select;
      logic [5:0] sel;
   } regulator_ctrl_t;

   // ************************************************************
   // Variant defaults: [variant][regulator five..eight in 0..3]
   // ************************************************************
   localparam logic [3:0][3:0][7:0] DEFAULT_CONTROL = {
      {8'h39, 8'h25, 8'h25, 8'h25},
      {8'h38, 8'h24, 8'h3f, 8'h38},
      {8'h3d, 8'h3c, 8'h24, 8'h36},
      {8'h3d, 8'h3c, 8'h24, 8'h36}};
   // Regulators turned on by the power-up sequence, per variant
   localparam logic [3:0][3:0] DEFAULT_SEQUENCED = {
      4'hf, 4'h2, 4'h8, 4'h8};

   // ************************************************************
   // Voltage table, millivolts
   // ************************************************************
   localparam logic [11:0] BASE_MV      = 12'h320;
   localparam logic [11:0] LOW_STEP_MV  = 12'h019;
   localparam logic [11:0] HIGH_BASE_MV = 12'h640;
   localparam logic [11:0] HIGH_STEP_MV = 12'h032;
   localparam logic [11:0] TOP_BASE_MV  = 12'hbb8;
   localparam logic [11:0] TOP_STEP_MV  = 12'h064;
   localparam logic [11:0] TOP_KNEE     = 12'h01c;

   // ************************************************************
   // Bus answers and state
   // ************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WR_ACCEPT = 2'b01,
      WR_RESP   = 2'b10
   } wr_state_t;

   typedef enum logic [1:0] {
      RD_ACCEPT = 2'b01,
      RD_DATA   = 2'b10
   } rd_state_t;

   typedef struct packed {
      wr_state_t              wr_state;
      rd_state_t              rd_state;
      logic                   awready;
      logic                   wready;
      logic                   aw_held;
      logic                   w_held;
      logic [7:0]             aw_addr;
      logic [7:0]             w_byte;
      logic                   w_strobe;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   arready;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      regulator_ctrl_t [3:0]  control;
   } bank_state_t;

endpackage

// >>> rtl/voltage_code_decoder.sv
`timescale 1ns/1ns
module voltage_code_decoder
   import regulator_regs_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_clock_en,
   input  wire logic [5:0]  i_code,
   output logic      [11:0] o_millivolts
);

   logic [11:0] next_millivolts;
   logic [11:0] step;

   // ************************************************************
   // Code to output voltage
   // ************************************************************
   // Lower half in fine steps, upper half coarse, last codes coarser
   always_comb begin
      step = {7'h00, i_code[4:0]};
      if (!i_code[SEL_MSB]) begin
         next_millivolts = BASE_MV + LOW_STEP_MV * step;
      end else if (step <= TOP_KNEE) begin
         next_millivolts = HIGH_BASE_MV + HIGH_STEP_MV * step;
      end else begin
         next_millivolts = TOP_BASE_MV + TOP_STEP_MV * (step - TOP_KNEE);
      end
   end

   // Registered so the readback never sees a combinational glitch
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_millivolts <= 12'h000;
      end else if (i_clock_en) begin
         o_millivolts <= next_millivolts;
      end
   end

endmodule // voltage_code_decoder

// >>> rtl/regulator_control_regs_5to8.sv
`timescale 1ns/1ns

module regulator_control_regs_5to8
   import regulator_regs_pkg::*;
#(
   parameter logic [1:0] VARIANT = 2'h0
)
(
   input  wire logic                   i_clock,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_clock_en,
   input  wire logic                   i_sequence_start,
   // AXI4-Lite write address
   input  wire logic                   i_awvalid,
   output logic                        o_awready,
   input  wire logic [7:0]             i_awaddr,
   input  wire logic [2:0]             i_awprot,
   // AXI4-Lite write data
   input  wire logic                   i_wvalid,
   output logic                        o_wready,
   input  wire logic [31:0]            i_wdata,
   input  wire logic [3:0]             i_wstrb,
   // AXI4-Lite write response
   output logic                        o_bvalid,
   input  wire logic                   i_bready,
   output logic [1:0]                  o_bresp,
   // AXI4-Lite read address
   input  wire logic                   i_arvalid,
   output logic                        o_arready,
   input  wire logic [7:0]             i_araddr,
   input  wire logic [2:0]             i_arprot,
   // AXI4-Lite read data
   output logic                        o_rvalid,
   input  wire logic                   i_rready,
   output logic [31:0]                 o_rdata,
   output logic [1:0]                  o_rresp,
   // Regulator controls and decoded voltages
   output regulator_ctrl_t [3:0]       o_regulator_control,
   output logic [3:0][11:0]            o_voltage_mv
);

   // ************************************************************
   // State
   // ************************************************************
   bank_state_t        state;
   bank_state_t        next_state;
   logic [3:0][11:0]   decoded_mv;
   logic               aw_go;
   logic               w_go;
   logic [5:0]         wr_index;
   logic [5:0]         rd_index;
   logic               wr_hit;
   logic               rd_hit;
   regulator_ctrl_t    written;

   // Protection bits carry no meaning for this bank
   logic               unused_prot;
   assign unused_prot = ^{i_awprot, i_arprot, i_wdata[31:8], i_wstrb[3:1]};

   // ************************************************************
   // Next-state logic
   // ************************************************************
   // Both bus channels and the register bank in one process
   always_comb begin
      next_state = state;
      aw_go      = i_awvalid && state.awready;
      w_go       = i_wvalid && state.wready;
      wr_index   = 6'h00;
      rd_index   = i_araddr[7:2];
      wr_hit     = 1'b0;
      rd_hit     = 1'b0;
      written    = regulator_ctrl_t'(state.w_byte);

      // Write channel: address and data may come in either order
      case (state.wr_state)
         WR_ACCEPT: begin
            if (aw_go) begin
               next_state.aw_held = 1'b1;
               next_state.aw_addr = i_awaddr;
               next_state.awready = 1'b0;
            end
            if (w_go) begin
               next_state.w_held   = 1'b1;
               next_state.w_byte   = i_wdata[7:0];
               next_state.w_strobe = i_wstrb[0];
               next_state.wready   = 1'b0;
            end
            if (next_state.aw_held && next_state.w_held) begin
               wr_index = next_state.aw_addr[7:2];
               written  = regulator_ctrl_t'(next_state.w_byte);
               // Only the low byte lane holds data; other lanes are ignored
               for (int r = 0; r < 4; r++) begin
                  if (wr_index == CONTROL_INDEX[r]) begin
                     wr_hit = 1'b1;
                     if (next_state.w_strobe) begin
                        next_state.control[r] = written;
                     end
                  end
                  if (wr_index == VOLTAGE_INDEX[r]) begin
                     wr_hit = 1'b1;
                  end
               end
               // The top code bit of regulator five cannot be cleared
               next_state.control[REGULATOR_FIVE].sel[SEL_MSB] = 1'b1;
               next_state.bresp    = wr_hit ? RESP_OKAY : RESP_SLVERR;
               next_state.bvalid   = 1'b1;
               next_state.aw_held  = 1'b0;
               next_state.w_held   = 1'b0;
               next_state.wr_state = WR_RESP;
            end
         end
         WR_RESP: begin
            if (i_bready) begin
               next_state.bvalid   = 1'b0;
               next_state.awready  = 1'b1;
               next_state.wready   = 1'b1;
               next_state.wr_state = WR_ACCEPT;
            end
         end
         default: begin
            next_state.bvalid   = 1'b0;
            next_state.awready  = 1'b1;
            next_state.wready   = 1'b1;
            next_state.aw_held  = 1'b0;
            next_state.w_held   = 1'b0;
            next_state.wr_state = WR_ACCEPT;
         end
      endcase

      // Power-up sequence step sets the sequenced enables; it wins over a write
      if (i_sequence_start) begin
         for (int r = 0; r < 4; r++) begin
            if (DEFAULT_SEQUENCED[VARIANT][r]) begin
               next_state.control[r].enable = 1'b1;
            end
         end
      end

      // Read channel: one read in flight, data captured at address
      case (state.rd_state)
         RD_ACCEPT: begin
            if (i_arvalid && state.arready) begin
               next_state.rdata = 32'h0000_0000;
               for (int r = 0; r < 4; r++) begin
                  if (rd_index == CONTROL_INDEX[r]) begin
                     rd_hit           = 1'b1;
                     next_state.rdata = {24'h00_0000, state.control[r]};
                  end
                  if (rd_index == VOLTAGE_INDEX[r]) begin
                     rd_hit           = 1'b1;
                     next_state.rdata = {20'h0_0000, decoded_mv[r]};
                  end
               end
               next_state.rresp    = rd_hit ? RESP_OKAY : RESP_SLVERR;
               next_state.rvalid   = 1'b1;
               next_state.arready  = 1'b0;
               next_state.rd_state = RD_DATA;
            end
         end
         RD_DATA: begin
            if (i_rready) begin
               next_state.rvalid   = 1'b0;
               next_state.arready  = 1'b1;
               next_state.rd_state = RD_ACCEPT;
            end
         end
         default: begin
            next_state.rvalid   = 1'b0;
            next_state.arready  = 1'b1;
            next_state.rd_state = RD_ACCEPT;
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Reset reloads the build-time defaults; enables always start off
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state          <= '0;
         state.wr_state <= WR_ACCEPT;
         state.rd_state <= RD_ACCEPT;
         state.awready  <= 1'b1;
         state.wready   <= 1'b1;
         state.arready  <= 1'b1;
         state.control  <= DEFAULT_CONTROL[VARIANT];
      end else if (i_clock_en) begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Voltage decode per regulator
   // ************************************************************
   // One registered decoder each; adds a cycle of lag after a write
   for (genvar g = 0; g < 4; g++) begin : g_decode
      voltage_code_decoder u_decoder (
         .i_clock      (i_clock),
         .i_rst_n      (i_rst_n),
         .i_clock_en   (i_clock_en),
         .i_code       (state.control[g].sel),
         .o_millivolts (decoded_mv[g])
      );
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // All straight from flip-flops
   assign o_awready           = state.awready;
   assign o_wready            = state.wready;
   assign o_bvalid            = state.bvalid;
   assign o_bresp             = state.bresp;
   assign o_arready           = state.arready;
   assign o_rvalid            = state.rvalid;
   assign o_rdata             = state.rdata;
   assign o_rresp             = state.rresp;
   assign o_regulator_control = state.control;
   assign o_voltage_mv        = decoded_mv;

endmodule // regulator_control_regs_5to8

// >>> testbench/regulator_control_regs_5to8_assertions.sv
`timescale 1ns/1ns
module regulator_control_regs_5to8_assertions
   import regulator_regs_pkg::*;
#(
   parameter logic [1:0] VARIANT = 2'h0
)
(
   input  wire logic                  i_clock,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_clock_en,
   input  wire logic                  i_sequence_start,
   input  wire logic                  i_awvalid,
   input  wire logic                  o_awready,
   input  wire logic [7:0]            i_awaddr,
   input  wire logic                  i_wvalid,
   input  wire logic                  o_wready,
   input  wire logic [31:0]           i_wdata,
   input  wire logic [3:0]            i_wstrb,
   input  wire logic                  o_bvalid,
   input  wire logic [1:0]            o_bresp,
   input  wire logic                  i_arvalid,
   input  wire logic                  o_arready,
   input  wire logic                  o_rvalid,
   input  wire regulator_ctrl_t [3:0] o_regulator_control,
   input  wire logic [3:0][11:0]      o_voltage_mv
);
   logic       take;
   logic [3:0] enables;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   // A write counts only when both halves meet while the clock runs
   assign take = i_awvalid && o_awready && i_wvalid && o_wready && i_clock_en;
   assign enables = {o_regulator_control[3].enable, o_regulator_control[2].enable,
                     o_regulator_control[1].enable, o_regulator_control[0].enable};

   // ************************************************************
   // Bus answers
   // ************************************************************
   a_write_answer_late : assert property (take |=> o_bvalid)
      else $error("write response not one cycle after acceptance");
   a_read_answer_late : assert property (i_arvalid && o_arready && i_clock_en |=> o_rvalid)
      else $error("read data not one cycle after acceptance");
   a_unmapped_error : assert property (take && i_awaddr < 8'h70 |=> o_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");

   // ************************************************************
   // Register fields
   // ************************************************************
   a_five_top_forced : assert property (
      take && i_wstrb[0] && i_awaddr == 8'h70
      |=> o_regulator_control[0].sel == {1'b1, $past(i_wdata[4:0])})
      else $error("regulator five code top bit not forced");
   a_six_full_code : assert property (
      take && i_wstrb[0] && i_awaddr == 8'h74
      |=> o_regulator_control[1].sel == $past(i_wdata[5:0]))
      else $error("regulator six code not stored");
   a_seven_power_save : assert property (
      take && i_wstrb[0] && i_awaddr == 8'h78
      |=> o_regulator_control[2].power_save_select == $past(i_wdata[6]))
      else $error("power save bit not stored");
   a_eight_whole_byte : assert property (
      take && i_wstrb[0] && i_awaddr == 8'h7c && !i_sequence_start
      |=> o_regulator_control[3] == $past(i_wdata[7:0]))
      else $error("regulator eight byte not stored");
   a_sequence_enables : assert property (
      i_sequence_start && i_clock_en
      |=> (enables & DEFAULT_SEQUENCED[VARIANT]) == DEFAULT_SEQUENCED[VARIANT])
      else $error("sequenced regulator not enabled");
   // Low half of the table only; the upper half is covered by the bench
   a_low_range_voltage : assert property (
      i_clock_en && o_regulator_control[1].sel < 6'h20
      |=> o_voltage_mv[1] == 12'h320 + 12'h019 * $past(o_regulator_control[1].sel))
      else $error("low range voltage wrong");
endmodule // regulator_control_regs_5to8_assertions

// >>> testbench/test_regulator_control_regs_5to8.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module test_regulator_control_regs_5to8
   import regulator_regs_pkg::*;
;
   localparam logic [3:0][7:0] RESET_VALUE = {8'h3d, 8'h3c, 8'h24, 8'h36};
   logic                  clk, rst_n, clk_en, seq, awvalid, wvalid, bready, arvalid, rready;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [7:0]            awaddr, araddr, exp;
   logic [31:0]           wdata, rdata, got;
   logic [3:0]            wstrb;
   logic [1:0]            bresp, rresp, resp;
   logic [3:0][7:0]       wval;
   logic [5:0][5:0]       codes;
   regulator_ctrl_t [3:0] ctrl;
   logic [3:0][11:0]      mv_out;
   int                    fail_count, checked;

   regulator_control_regs_5to8 #(.VARIANT(2'h0)) i_regulator_control_regs_5to8 (
      .i_clock(clk), .i_rst_n(rst_n), .i_clock_en(clk_en), .i_sequence_start(seq),
      .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_awprot(3'h0),
      .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
      .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .i_arprot(3'h0),
      .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
      .o_regulator_control(ctrl), .o_voltage_mv(mv_out));

   // ************************************************************
   // Clock, watchdog and verdict
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // The whole run needs well under a thousand cycles
   initial begin
      #20000;
      fail_count++;
      end_sim();
   end

   task automatic end_sim();
      if (fail_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ************************************************************
   // Bus tasks and expectations
   // ************************************************************
   // Responses are always accepted, so bready and rready stay high
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s,
                     output logic [1:0] r);
      @(posedge clk);
      {awvalid, wvalid} <= 2'h3;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= {3'h0, s};
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
   endtask

   function automatic logic [11:0] mv(input logic [5:0] c);
      if (c < 6'h20) return 12'h320 + 12'h019 * c;
      if (c < 6'h3d) return 12'h640 + 12'h032 * (c - 6'h20);
      return 12'hbb8 + 12'h064 * (c - 6'h3c);
   endfunction

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic chk_def();
      for (int i = 0; i < 4; i++) begin
         rd(8'(32'h70 + 4 * i), got, resp);
         `CHK(got, {24'h0, RESET_VALUE[i]})
         `CHK(mv_out[i], mv(RESET_VALUE[i][5:0]))
      end
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {clk_en, bready, rready} <= 3'h7;
      {seq, awvalid, wvalid, arvalid} <= 4'h0;
      {awaddr, araddr, wdata, wstrb} <= 52'h0;
      do_reset();
      chk_def();
      // Index 0 is regulator five, whose code top bit is held at 1
      wval = {8'h9d, 8'hbf, 8'h40, 8'hc5};
      for (int i = 0; i < 4; i++) begin
         exp = wval[i] | (i == 0 ? 8'h20 : 8'h0);
         wr(8'(32'h70 + 4 * i), wval[i], 1'b1, resp);
         `CHK(resp, RESP_OKAY)
         rd(8'(32'h70 + 4 * i), got, resp);
         `CHK({got, resp}, {24'h0, exp, RESP_OKAY})
         `CHK(ctrl[i], exp)
         `CHK(mv_out[i], mv(exp[5:0]))
      end
      // Both ends and both knees of the table on six; five, with its top bit held, sees only the upper half
      codes = {6'h3f, 6'h3d, 6'h3c, 6'h20, 6'h1f, 6'h00};
      for (int j = 0; j < 6; j++) begin
         for (int r = 0; r < 2; r++) begin
            exp = {2'h0, codes[j]} | (r == 0 ? 8'h20 : 8'h0);
            wr(8'(32'h70 + 4 * r), {2'h0, codes[j]}, 1'b1, resp);
            rd(8'(32'h70 + 4 * r), got, resp);
            `CHK(got, {24'h0, exp})
            `CHK(mv_out[r], mv(exp[5:0]))
            rd(8'(32'h80 + 4 * r), got, resp);
            `CHK({got, resp}, {20'h0, mv(exp[5:0]), RESP_OKAY})
         end
      end
      // Lane 0 disabled leaves six at the last swept code; readback ignores writes
      wr(8'h74, 8'hff, 1'b0, resp);
      `CHK(resp, RESP_OKAY)
      rd(8'h74, got, resp);
      `CHK({got, resp}, {26'h0, codes[5], RESP_OKAY})
      wr(8'h84, 8'h00, 1'b1, resp);
      `CHK(resp, RESP_OKAY)
      rd(8'h84, got, resp);
      `CHK({got, resp}, {20'h0, mv(codes[5]), RESP_OKAY})
      // A hole answers with an error
      wr(8'h6c, 8'hff, 1'b1, resp);
      `CHK(resp, RESP_SLVERR)
      rd(8'h6c, got, resp);
      `CHK({got, resp}, {32'h0, RESP_SLVERR})
      do_reset();
      chk_def();
      // A start pulse with the clock frozen has no effect until the clock runs, then enables eight
      clk_en <= 1'b0;
      seq <= 1'b1;
      @(posedge clk);
      #1;
      `CHK(ctrl, RESET_VALUE)
      @(posedge clk);
      clk_en <= 1'b1;
      @(posedge clk);
      seq <= 1'b0;
      #1;
      for (int i = 0; i < 4; i++) begin
         `CHK(ctrl[i], RESET_VALUE[i] | {i == 3, 7'h0})
      end
      // A start pulse landing with a write that clears the enable must win
      fork
         wr(8'h7c, 8'h3d, 1'b1, resp);
         begin
            @(posedge clk);
            seq <= 1'b1;
            @(posedge clk);
            seq <= 1'b0;
         end
      join
      `CHK(ctrl[3], 8'hbd)
      end_sim();
   end
endmodule // test_regulator_control_regs_5to8

bind regulator_control_regs_5to8 regulator_control_regs_5to8_assertions #(.VARIANT(VARIANT))
   i_regulator_control_regs_5to8_assertions (.i_clock, .i_rst_n, .i_clock_en,
   .i_sequence_start, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
   .i_wstrb, .o_bvalid, .o_bresp, .i_arvalid, .o_arready, .o_rvalid, .o_regulator_control,
   .o_voltage_mv);
